// file: logic/ctp_host.sv
// Host controller for the cascadable timer pair: APB slave registers,
// device register programming sequencer, event source, output monitor.
// Assumes the device takes one register write per valid cycle.
`timescale 1ns/1ps
`include "ctp_regs.svh"
module ctp_host #(
  parameter int MACH_CYC_CLKS = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device register port
  output ctp_pkg::ctp_dev_wr_s dev_wr,
  // Device pins
  output logic event_input_pin,
  input wire logic divider_output_pin,
  input wire logic match_interrupt
);
  import ctp_pkg::*;

  localparam int MIN_PHASE = 2 * MACH_CYC_CLKS;

  ctp_cfg_s cfg_r;
  ctp_cfg_s act_r;
  logic [15:0] cmp_r;
  logic [15:0] duty_r;
  logic [15:0] pcount_r;
  logic [7:0] pphase_r;
  logic [3:0] err_r;
  logic run_r;
  logic [15:0] edge_cnt_r;
  logic [15:0] match_cnt_r;
  logic pin_q_r;
  logic irq_q_r;
  ctp_state_e state_r;
  ctp_state_e state_nxt;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_flop;
  logic pulse_go;
  logic pulse_busy;
  logic bad_range;
  logic bad_clk;
  logic bad_flop;
  logic bad_seq;
  logic wide;

  // ****************************************************************
  // Checking and control byte functions
  // ****************************************************************
  // Compare and duty limits for each mode
  function automatic logic range_bad(ctp_mode_e m, logic [15:0] c,
                                     logic [15:0] d);
    logic r;
    r = 1'b0;
    unique case (m)
      CTP_M_TMR8, CTP_M_DIV8:
        r = c < `CTP_MIN_CMP || c > `CTP_MAX_CMP8;
      CTP_M_PWM8:
        r = d < `CTP_MIN_DUTY || d > `CTP_MAX_DUTY8;
      CTP_M_TMR16:
        r = c < `CTP_MIN_CMP;
      CTP_M_WARM:
        r = c < `CTP_MIN_WARM;
      CTP_M_PWM16:
        r = d < `CTP_MIN_DUTY || d > `CTP_MAX_DUTY16;
      CTP_M_PPG16:
        r = d < `CTP_MIN_CMP || {1'b0, d} + 17'h00001 >= {1'b0, c};
      CTP_M_RSVD:
        r = 1'b1;
    endcase
    return r;
  endfunction

  // Clock selects allowed while the device runs at low speed
  function automatic logic clk_bad(ctp_mode_e m, logic [2:0] k);
    logic ok;
    ok = 1'b0;
    unique case (m)
      CTP_M_TMR8: ok = k == `CTP_CK_SLOW_PRE || k == `CTP_CK_PIN;
      CTP_M_DIV8, CTP_M_PPG16: ok = k == `CTP_CK_SLOW_PRE;
      CTP_M_PWM8: ok = k == `CTP_CK_SLOW_PRE || k == `CTP_CK_SLOW_RAW;
      CTP_M_TMR16: ok = k == `CTP_CK_SLOW_PRE || k == `CTP_CK_PIN;
      CTP_M_WARM: ok = k == `CTP_CK_FAST;
      CTP_M_PWM16: ok = k == `CTP_CK_SLOW_PRE || k == `CTP_CK_SLOW_RAW
                        || k == `CTP_CK_PIN;
      CTP_M_RSVD: ok = 1'b0;
    endcase
    return !ok;
  endfunction

  // Control byte: flop, clock select, run, mode
  function automatic logic [7:0] ctl_byte(logic f, logic [2:0] k,
                                          logic run, logic [2:0] m);
    return {f, k, run, m};
  endfunction

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Zero wait states keep the master's access phase to one cycle
  assign pready = 1'b1;
  assign addr_ok = paddr == `CTP_OFF_CFG || paddr == `CTP_OFF_CMP ||
                   paddr == `CTP_OFF_CMD || paddr == `CTP_OFF_PULSE ||
                   paddr == `CTP_OFF_STAT || paddr == `CTP_OFF_EVT;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_acc = psel && penable && pwrite && addr_ok;
  assign rd_acc = psel && penable && !pwrite;
  assign cmd_start = wr_acc && paddr == `CTP_OFF_CMD &&
                     pwdata[`CTP_CMD_START_BIT];
  assign cmd_stop = wr_acc && paddr == `CTP_OFF_CMD &&
                    pwdata[`CTP_CMD_STOP_BIT];
  assign cmd_flop = wr_acc && paddr == `CTP_OFF_CMD &&
                    pwdata[`CTP_CMD_FLOP_BIT];
  assign pulse_go = wr_acc && paddr == `CTP_OFF_PULSE;

  // Configuration, compare and pulse request registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r <= ctp_cfg_s'(`CTP_CFG_RST);
      cmp_r <= 16'h0000;
      duty_r <= 16'h0000;
      pcount_r <= 16'h0000;
      pphase_r <= 8'h00;
    end
    else if (wr_acc)
    begin
      if (paddr == `CTP_OFF_CFG)
        cfg_r <= ctp_cfg_s'(pwdata[8:0]);
      if (paddr == `CTP_OFF_CMP)
      begin
        cmp_r <= pwdata[15:0];
        duty_r <= pwdata[31:16];
      end
      if (paddr == `CTP_OFF_PULSE)
      begin
        pcount_r <= pwdata[15:0];
        pphase_r <= pwdata[23:16];
      end
    end
  end

  // Read mux over flops only
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_acc)
    begin
      unique case (paddr)
        `CTP_OFF_CFG: prdata = {23'h000000, cfg_r};
        `CTP_OFF_CMP: prdata = {duty_r, cmp_r};
        `CTP_OFF_PULSE: prdata = {8'h00, pphase_r, pcount_r};
        `CTP_OFF_STAT: prdata = {24'h000000, run_r, err_r, pin_q_r,
                                 pulse_busy, state_r != CTP_S_IDLE};
        `CTP_OFF_EVT: prdata = {match_cnt_r, edge_cnt_r};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Command checks
  // ****************************************************************
  // A start is refused outright rather than half programmed
  assign bad_range = cmd_start && range_bad(cfg_r.mode, cmp_r, duty_r);
  assign bad_clk = cmd_start && cfg_r.slow &&
                   clk_bad(cfg_r.mode, cfg_r.clk);
  assign bad_flop = cmd_start && cfg_r.flop &&
                    (cfg_r.mode == CTP_M_TMR8 ||
                     cfg_r.mode == CTP_M_TMR16);
  // Compare rewrite or flop write while running is unsafe
  assign bad_seq = (cmd_start || cmd_flop) &&
                   (run_r || state_r != CTP_S_IDLE);
  assign wide = act_r.mode[2];

  // Sticky errors, set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_r <= 4'h0;
    else
      err_r <= (err_r & ~((wr_acc && paddr == `CTP_OFF_STAT) ?
                          pwdata[6:3] : 4'h0)) |
               {bad_seq, bad_flop, bad_clk, bad_range};
  end

  // ****************************************************************
  // Programming sequencer
  // ****************************************************************
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      CTP_S_IDLE:
        if (cmd_start && !(bad_range || bad_clk || bad_flop || bad_seq))
          state_nxt = (cfg_r.mode == CTP_M_DIV8) ? CTP_S_LATCH : CTP_S_CMP_A;
        else if (cmd_stop && run_r)
          state_nxt = CTP_S_STOP;
        else if (cmd_flop && !bad_seq)
          state_nxt = CTP_S_FLOP;
      CTP_S_LATCH: state_nxt = CTP_S_CMP_A;
      CTP_S_CMP_A: state_nxt = wide ? CTP_S_CMP_B : CTP_S_DUTY_A;
      CTP_S_CMP_B: state_nxt = CTP_S_DUTY_A;
      CTP_S_DUTY_A:
        state_nxt = wide ? CTP_S_DUTY_B : CTP_S_CTL_CFG;
      CTP_S_DUTY_B: state_nxt = CTP_S_CTL_LO;
      CTP_S_CTL_LO: state_nxt = CTP_S_CTL_CFG;
      CTP_S_CTL_CFG: state_nxt = CTP_S_CTL_RUN;
      CTP_S_CTL_RUN, CTP_S_STOP, CTP_S_FLOP: state_nxt = CTP_S_IDLE;
      default: state_nxt = CTP_S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= CTP_S_IDLE;
    else
      state_r <= state_nxt;
  end

  // Configuration snapshot taken as a start or flop write is accepted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      act_r <= ctp_cfg_s'(`CTP_CFG_RST);
    else if (state_r == CTP_S_IDLE &&
             (state_nxt == CTP_S_LATCH || state_nxt == CTP_S_CMP_A ||
              state_nxt == CTP_S_FLOP))
      act_r <= cfg_r;
  end

  // Running flag follows the device's run bit as written
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_r <= 1'b0;
    else if (state_r == CTP_S_CTL_RUN)
      run_r <= 1'b1;
    else if (state_r == CTP_S_STOP)
      run_r <= 1'b0;
  end

  // One device write per sequencer step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dev_wr <= '0;
    else
    begin
      dev_wr.valid <= state_r != CTP_S_IDLE;
      dev_wr.addr <= `CTP_DEV_LATCH;
      dev_wr.data <= `CTP_LATCH_ON;
      unique case (state_r)
        CTP_S_CMP_A:
        begin
          // Lower byte first when the pair is joined
          dev_wr.addr <= (act_r.upper && !wide) ?
                         `CTP_DEV_CMP_HI : `CTP_DEV_CMP_LO;
          dev_wr.data <= cmp_r[7:0];
        end
        CTP_S_CMP_B:
        begin
          dev_wr.addr <= `CTP_DEV_CMP_HI;
          dev_wr.data <= cmp_r[15:8];
        end
        CTP_S_DUTY_A:
        begin
          dev_wr.addr <= (act_r.upper && !wide) ?
                         `CTP_DEV_DUTY_HI : `CTP_DEV_DUTY_LO;
          dev_wr.data <= duty_r[7:0];
        end
        CTP_S_DUTY_B:
        begin
          dev_wr.addr <= `CTP_DEV_DUTY_HI;
          dev_wr.data <= duty_r[15:8];
        end
        CTP_S_CTL_LO:
        begin
          // Joined pair takes its clock from the lower select
          dev_wr.addr <= `CTP_DEV_CTL_LO;
          dev_wr.data <= ctl_byte(1'b0, act_r.clk, 1'b0,
                                  `CTP_LOWER_CASCADE);
        end
        CTP_S_CTL_CFG, CTP_S_CTL_RUN, CTP_S_STOP, CTP_S_FLOP:
        begin
          dev_wr.addr <= (act_r.upper || wide) ?
                         `CTP_DEV_CTL_HI : `CTP_DEV_CTL_LO;
          // Stop keeps the flop bit; a new level needs its own write
          dev_wr.data <= ctl_byte(act_r.flop, act_r.clk,
                                  state_r == CTP_S_CTL_RUN,
                                  act_r.mode);
        end
        default:
        begin
          dev_wr.addr <= `CTP_DEV_LATCH;
          dev_wr.data <= `CTP_LATCH_ON;
        end
      endcase
    end
  end

  // ****************************************************************
  // Event source and output monitor
  // ****************************************************************
  ctp_pulse_gen #(
    .MIN_PHASE(MIN_PHASE)
  ) u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .start(pulse_go),
    .count(pwdata[15:0]),
    .phase(pwdata[23:16]),
    .event_input_pin(event_input_pin),
    .busy(pulse_busy)
  );

  // Divider pin edges and match pulses, counted for software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_q_r <= 1'b1;
      irq_q_r <= 1'b0;
      edge_cnt_r <= 16'h0000;
      match_cnt_r <= 16'h0000;
    end
    else
    begin
      // Pin idles high: complement of a cleared flop
      pin_q_r <= divider_output_pin;
      irq_q_r <= match_interrupt;
      if (divider_output_pin != pin_q_r)
        edge_cnt_r <= edge_cnt_r + 16'h0001;
      if (match_interrupt && !irq_q_r)
        match_cnt_r <= match_cnt_r + 16'h0001;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_cfg_steps;
    state_r == CTP_S_CTL_CFG ##1 state_r == CTP_S_CTL_RUN;
  endsequence

  // A start during a running sequence is refused too, but the state moves on
  a_range_refused: assert property (@(posedge pclk) disable iff (!presetn)
    bad_range && state_r == CTP_S_IDLE |=> err_r[0] && state_r == CTP_S_IDLE)
    else $error("bad compare value not refused");

  a_clk_refused: assert property (@(posedge pclk) disable iff (!presetn)
    bad_clk && state_r == CTP_S_IDLE |=> err_r[1] && state_r == CTP_S_IDLE)
    else $error("bad low speed clock not refused");

  a_flop_zero: assert property (@(posedge pclk) disable iff (!presetn)
    dev_wr.valid && dev_wr.addr[2:1] == 2'b10 && dev_wr.data[3] &&
    dev_wr.data[2:0] == 3'b000 |-> !dev_wr.data[7])
    else $error("flop set in timer mode");

  a_no_cmp_run: assert property (@(posedge pclk) disable iff (!presetn)
    dev_wr.valid && dev_wr.addr <= `CTP_DEV_CMP_HI |-> !run_r)
    else $error("compare written while running");

  a_run_after_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    s_cfg_steps |=> dev_wr.valid && dev_wr.data[3] ##1 run_r)
    else $error("run not issued after config");

  a_stop_keeps_flop: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CTP_S_STOP |=> dev_wr.valid && !dev_wr.data[3] &&
    dev_wr.data[7] == act_r.flop ##1 !run_r)
    else $error("stop changed flop level");

  a_latch_first: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CTP_S_LATCH |=> dev_wr.addr == `CTP_DEV_LATCH &&
    dev_wr.data == `CTP_LATCH_ON ##1 dev_wr.addr != `CTP_DEV_LATCH)
    else $error("port latch not set before divider");

  a_lower_clock: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CTP_S_CTL_LO |=> dev_wr.addr == `CTP_DEV_CTL_LO &&
    dev_wr.data[6:4] == act_r.clk ##[2:2] dev_wr.addr == `CTP_DEV_CTL_HI)
    else $error("joined pair clock not on lower");

  a_order_wide: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CTP_S_CMP_A && wide |=> dev_wr.addr == `CTP_DEV_CMP_LO
    ##1 dev_wr.addr == `CTP_DEV_CMP_HI)
    else $error("compare bytes out of order");

endmodule

// file: logic/ctp_regs.svh
// Offsets, fields and counts for the timer pair host controller.
// Assumes includes by bare name; definitions only.
`ifndef CTP_REGS_SVH
`define CTP_REGS_SVH

// ****************************************************************
// APB register offsets (byte addresses)
// ****************************************************************
`define CTP_OFF_CFG 12'h000
`define CTP_OFF_CMP 12'h004
`define CTP_OFF_CMD 12'h008
`define CTP_OFF_PULSE 12'h00c
`define CTP_OFF_STAT 12'h010
`define CTP_OFF_EVT 12'h014

// ****************************************************************
// Field positions
// ****************************************************************
`define CTP_CFG_MODE_LSB 0
`define CTP_CFG_CLK_LSB 3
`define CTP_CFG_FLOP_BIT 6
`define CTP_CFG_UPPER_BIT 7
`define CTP_CFG_SLOW_BIT 8
`define CTP_CMD_START_BIT 0
`define CTP_CMD_STOP_BIT 1
`define CTP_CMD_FLOP_BIT 2
`define CTP_ST_BUSY 0
`define CTP_ST_PULSE 1
`define CTP_ST_PIN 2
`define CTP_ST_ERR_RANGE 3
`define CTP_ST_ERR_CLK 4
`define CTP_ST_ERR_FLOP 5
`define CTP_ST_ERR_SEQ 6
`define CTP_ST_RUN 7
`define CTP_CFG_RST 9'h000

// ****************************************************************
// Device register targets and control byte layout
// ****************************************************************
`define CTP_DEV_CMP_LO 3'h0
`define CTP_DEV_CMP_HI 3'h1
`define CTP_DEV_DUTY_LO 3'h2
`define CTP_DEV_DUTY_HI 3'h3
`define CTP_DEV_CTL_LO 3'h4
`define CTP_DEV_CTL_HI 3'h5
`define CTP_DEV_LATCH 3'h6
`define CTP_LATCH_ON 8'h01
`define CTP_LOWER_CASCADE 3'h3

// ****************************************************************
// Compare limits
// ****************************************************************
`define CTP_MIN_CMP 16'h0001
`define CTP_MAX_CMP8 16'h00ff
`define CTP_MIN_DUTY 16'h0002
`define CTP_MAX_DUTY8 16'h00fe
`define CTP_MAX_DUTY16 16'hfffe
`define CTP_MIN_WARM 16'h0100

// ****************************************************************
// Clock select codes permitted at low speed
// ****************************************************************
`define CTP_CK_SLOW_PRE 3'h0
`define CTP_CK_SLOW_RAW 3'h4
`define CTP_CK_FAST 3'h6
`define CTP_CK_PIN 3'h7

`endif

// file: logic/ctp_pkg.sv
// Types shared by the timer pair host controller.
// Assumes nothing beyond a SystemVerilog compiler.
package ctp_pkg;

  // Mode field codes of the device
  typedef enum logic [2:0] {
    CTP_M_TMR8 = 3'h0,
    CTP_M_DIV8 = 3'h1,
    CTP_M_PWM8 = 3'h2,
    CTP_M_RSVD = 3'h3,
    CTP_M_TMR16 = 3'h4,
    CTP_M_WARM = 3'h5,
    CTP_M_PWM16 = 3'h6,
    CTP_M_PPG16 = 3'h7
  } ctp_mode_e;

  // Programming sequencer states
  typedef enum logic [10:0] {
    CTP_S_IDLE = 11'h001,
    CTP_S_LATCH = 11'h002,
    CTP_S_CMP_A = 11'h004,
    CTP_S_CMP_B = 11'h008,
    CTP_S_DUTY_A = 11'h010,
    CTP_S_DUTY_B = 11'h020,
    CTP_S_CTL_LO = 11'h040,
    CTP_S_CTL_CFG = 11'h080,
    CTP_S_CTL_RUN = 11'h100,
    CTP_S_STOP = 11'h200,
    CTP_S_FLOP = 11'h400
  } ctp_state_e;

  // One write to the device's own register port
  typedef struct packed {
    logic valid;
    logic [2:0] addr;
    logic [7:0] data;
  } ctp_dev_wr_s;

  // Stored configuration
  typedef struct packed {
    logic slow;
    logic upper;
    logic flop;
    logic [2:0] clk;
    ctp_mode_e mode;
  } ctp_cfg_s;

endpackage

// file: logic/ctp_pulse_gen.sv
// Event pulse train source for the device's event input pin.
// Assumes pclk is the only clock; start is a one-cycle pulse.
`timescale 1ns/1ps
module ctp_pulse_gen #(
  parameter int MIN_PHASE = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request
  input wire logic start,
  input wire logic [15:0] count,
  input wire logic [7:0] phase,
  // Pin and status
  output logic event_input_pin,
  output logic busy
);
  import ctp_pkg::*;

  logic [15:0] rem_r;
  logic [15:0] len_r;
  logic [15:0] tick_r;
  logic [15:0] low_len_r;

  // ****************************************************************
  // Phase generator
  // ****************************************************************
  // Phase length never shorter than two machine cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rem_r <= 16'h0000;
      len_r <= 16'h0000;
      tick_r <= 16'h0000;
      event_input_pin <= 1'b1;
    end
    else if (!busy)
    begin
      if (start && count != 16'h0000)
      begin
        rem_r <= count;
        len_r <= ({8'h00, phase} < 16'(MIN_PHASE)) ?
                 16'(MIN_PHASE) : {8'h00, phase};
        tick_r <= 16'h0001;
        event_input_pin <= 1'b0;
      end
    end
    else if (tick_r < len_r)
      tick_r <= tick_r + 16'h0001;
    else
    begin
      tick_r <= 16'h0001;
      if (!event_input_pin)
        event_input_pin <= 1'b1;
      else if (rem_r == 16'h0001)
        rem_r <= 16'h0000;
      else
      begin
        rem_r <= rem_r - 16'h0001;
        event_input_pin <= 1'b0;
      end
    end
  end

  // Busy until the last high phase has run out
  assign busy = (rem_r != 16'h0000);

  // Low phase length, read by the checks only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_len_r <= 16'h0000;
    else if (event_input_pin)
      low_len_r <= 16'h0000;
    else
      low_len_r <= low_len_r + 16'h0001;
  end

  a_low_phase_min: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(event_input_pin) |-> $past(low_len_r) >= 16'(MIN_PHASE - 1))
    else $error("event low phase too short");

  a_high_phase_min: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(event_input_pin) |=> event_input_pin [*2])
    else $error("event high phase too short");

endmodule

// file: dv/ctp_dev_model.sv
// Behavioural timer pair device behind the host's register port.
// Assumes one device register write per dev_wr.valid pulse.
`timescale 1ns/1ps
module ctp_dev_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register port and pins
  input wire ctp_pkg::ctp_dev_wr_s dev_wr,
  input wire logic event_input_pin,
  output logic divider_output_pin,
  output logic match_interrupt
);
  import ctp_pkg::*;
  logic [7:0] ctl_r, lo_r, hi_r;
  logic [15:0] cnt_r, cmp_w;
  logic [2:0] sync_r;
  logic flop_r, tick, hit;
  // Pin events count only on a clean synchronized fall
  assign tick = (ctl_r[6:4] == 3'h7) ?
                (sync_r[2] & ~sync_r[1]) : 1'b1;
  assign cmp_w = ctl_r[2] ? {hi_r, lo_r} : {8'h00, lo_r};
  assign hit = ctl_r[3] & tick & (cnt_r + 16'h0001 == cmp_w);
  assign divider_output_pin = ~flop_r;
  // No shadow stage: writes take effect at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_r <= 8'h00;
      lo_r <= 8'h00;
      hi_r <= 8'h00;
    end
    else if (dev_wr.valid)
    begin
      case (dev_wr.addr)
        3'h0: lo_r <= dev_wr.data;
        3'h1: hi_r <= dev_wr.data;
        3'h4, 3'h5: ctl_r <= dev_wr.data;
        default: ;
      endcase
    end
  end
  // Flop loads only while already stopped, so the stop write holds the pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flop_r <= 1'b0;
    else if (dev_wr.valid && dev_wr.addr[2:1] == 2'h2 && !dev_wr.data[3] &&
             !ctl_r[3])
      flop_r <= dev_wr.data[7];
    else if (hit && ctl_r[2:0] == 3'h1)
      flop_r <= ~flop_r;
  end
  // Counter clears when stopped or on a match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 16'h0000;
      sync_r <= 3'h7;
      match_interrupt <= 1'b0;
    end
    else
    begin
      sync_r <= {sync_r[1:0], event_input_pin};
      match_interrupt <= hit;
      if (!ctl_r[3] || hit)
        cnt_r <= 16'h0000;
      else if (tick)
        cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule

// file: dv/test_cascadable_timer_pair.sv
// Self-checking bench for the timer pair host controller.
// Assumes the device model and the design files are compiled first.
`timescale 1ns/1ps
`include "ctp_regs.svh"
module test_cascadable_timer_pair;
  import ctp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, q0, q1;
  logic [31:0] seed = 32'h22;
  logic pready, pslverr, err, dpin, mint, epin;
  ctp_dev_wr_s dev_wr;
  int n_errors = 0;
  int compares = 0;
  int latch_wr = 0;
  int c, n;
  logic [31:0] bcfg [7] = '{32'h40, 32'h0, 32'h0, 32'h25, 32'h108, 32'h3, 32'h2};
  logic [31:0] bcmp [7] = '{32'h1, 32'h0, 32'h100, 32'hff, 32'h1, 32'h1,
    32'h10001};
  logic [31:0] bbit [7] = '{32'h20, 32'h8, 32'h8, 32'h8, 32'h10, 32'h8, 32'h8};
  ctp_host #(.MACH_CYC_CLKS(2)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_wr(dev_wr), .event_input_pin(epin), .divider_output_pin(dpin),
    .match_interrupt(mint));
  ctp_dev_model u_dev (.pclk(pclk), .presetn(presetn), .dev_wr(dev_wr),
    .event_input_pin(epin), .divider_output_pin(dpin),
    .match_interrupt(mint));
  always #5 pclk = ~pclk;
  // Port latch writes seen on the device register port
  always @(posedge pclk)
    if (dev_wr.valid === 1'b1 && dev_wr.addr === `CTP_DEV_LATCH)
      latch_wr += (dev_wr.data === `CTP_LATCH_ON);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // ********
  // APB master, one transfer
  // ********
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Polls a status bit until it drops, bounded
  task automatic idle(input int b);
    for (int i = 0; i < 300; i++)
    begin
      apb(1'b0, `CTP_OFF_STAT, 32'h0);
      if (q[b] === 1'b0)
        break;
    end
    chk(32'(q[b]), 32'h0);
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial
  begin
    #800000;
    n_errors++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CTP_OFF_CFG, 32'h0);
    chk(q, 32'(`CTP_CFG_RST));
    apb(1'b0, `CTP_OFF_STAT, 32'h0);
    chk(q & 32'h4, 32'h4);
    apb(1'b0, 12'h018, 32'h0);
    chk({q[30:0], err}, 32'h1);
    // Refused starts raise one sticky error each
    for (c = 0; c < 7; c++)
    begin
      apb(1'b1, `CTP_OFF_CFG, bcfg[c]);
      apb(1'b1, `CTP_OFF_CMP, bcmp[c]);
      apb(1'b1, `CTP_OFF_CMD, 32'h1);
      apb(1'b0, `CTP_OFF_STAT, 32'h0);
      chk(q & 32'hf8, bbit[c]);
      apb(1'b1, `CTP_OFF_STAT, 32'h78);
    end
    // Event counting from a random pulse train
    seed = xs(seed);
    c = int'(seed[2:0]) + 1;
    n = int'(seed[12:8]) + 8;
    apb(1'b1, `CTP_OFF_CFG, 32'h38);
    apb(1'b1, `CTP_OFF_CMP, 32'(c));
    apb(1'b1, `CTP_OFF_CMD, 32'h1);
    idle(0);
    apb(1'b0, `CTP_OFF_EVT, 32'h0);
    q0 = q;
    apb(1'b1, `CTP_OFF_PULSE, {16'h0002, 16'(n)});
    idle(1);
    repeat (8) @(posedge pclk);
    apb(1'b0, `CTP_OFF_EVT, 32'h0);
    chk(32'(q[31:16] - q0[31:16]), 32'(n / c));
    apb(1'b1, `CTP_OFF_CMD, 32'h2);
    idle(0);
    // Divider run, stop, then hold
    seed = xs(seed);
    c = int'(seed[2:0]) + 2;
    latch_wr = 0;
    apb(1'b1, `CTP_OFF_CFG, 32'h1);
    apb(1'b1, `CTP_OFF_CMP, 32'(c));
    apb(1'b0, `CTP_OFF_EVT, 32'h0);
    q0 = q;
    apb(1'b1, `CTP_OFF_CMD, 32'h1);
    idle(0);
    chk(32'(latch_wr), 32'h1);
    repeat (300) @(posedge pclk);
    apb(1'b1, `CTP_OFF_CMD, 32'h2);
    idle(0);
    apb(1'b0, `CTP_OFF_EVT, 32'h0);
    q1 = q;
    chk(32'(q1[15:0] - q0[15:0]), 32'(q1[31:16] - q0[31:16]));
    chk(32'((q1[31:16] - q0[31:16]) > 16'(200 / c)), 32'h1);
    repeat (60) @(posedge pclk);
    apb(1'b0, `CTP_OFF_EVT, 32'h0);
    chk(q, q1);
    apb(1'b0, `CTP_OFF_STAT, 32'h0);
    chk(q & 32'h4, {29'h0, ~(q1[16] ^ q0[16]), 2'b00});
    // Flop writes while stopped set the pin to the complement
    for (c = 0; c < 2; c++)
    begin
      apb(1'b1, `CTP_OFF_CFG, 32'h1 | (32'(c) << 6));
      apb(1'b1, `CTP_OFF_CMD, 32'h4);
      idle(0);
      apb(1'b0, `CTP_OFF_STAT, 32'h0);
      chk(q & 32'h4, (c == 0) ? 32'h4 : 32'h0);
    end
    // Joined pair: a compare above 255 needs both bytes
    latch_wr = 0;
    apb(1'b1, `CTP_OFF_CFG, 32'h4);
    apb(1'b1, `CTP_OFF_CMP, 32'h0000_0103);
    apb(1'b0, `CTP_OFF_EVT, 32'h0);
    q0 = q;
    apb(1'b1, `CTP_OFF_CMD, 32'h1);
    repeat (800) @(posedge pclk);
    apb(1'b0, `CTP_OFF_EVT, 32'h0);
    chk(32'(q[31:16] - q0[31:16]), 32'h3);
    chk(32'(latch_wr), 32'h0);
    complete_run();
  end
endmodule
